/* rtl/oofr_pkg.sv */
// Constants and types shared by the output over-voltage fault response block.
// Assumes a single 125 MHz clock domain and a decoded command port from the bus engine.
`default_nettype none

package oofr_pkg;

    // Command codes through which the host reaches the three settings.
    localparam logic [7:0]  CMD_CURRENT_SENSE_OFFSET = 8'h39;
    localparam logic [7:0]  CMD_OV_FAULT_THRESHOLD   = 8'h40;
    localparam logic [7:0]  CMD_OV_FAULT_POLICY      = 8'h41;

    // Field positions inside the policy byte.
    localparam int          RESP_MSB  = 7;
    localparam int          RESP_LSB  = 6;
    localparam int          RETRY_MSB = 5;
    localparam int          RETRY_LSB = 3;
    localparam int          DELAY_MSB = 2;
    localparam int          DELAY_LSB = 0;

    // Field positions of a linear-format word: signed exponent over signed mantissa.
    localparam int          LIN_EXP_MSB = 15;
    localparam int          LIN_EXP_LSB = 11;
    localparam int          LIN_MAN_MSB = 10;

    // Threshold and measured voltage share this fixed exponent, so they compare directly.
    localparam int          OV_EXPONENT = -12;

    // Response codes.
    localparam logic [1:0]  RESP_IGNORE        = 2'h0;
    localparam logic [1:0]  RESP_DELAY_RETRY   = 2'h1;
    localparam logic [1:0]  RESP_DISABLE_RETRY = 2'h2;
    localparam logic [1:0]  RESP_RESUME_OK     = 2'h3;

    // Retry codes with special meaning.
    localparam logic [2:0]  RETRY_NONE    = 3'h0;
    localparam logic [2:0]  RETRY_FOREVER = 3'h7;

    // Values after reset.
    localparam logic [15:0] RST_CURRENT_SENSE_OFFSET = 16'h0000;
    localparam logic [15:0] RST_OV_FAULT_THRESHOLD   = 16'hFFFF;
    localparam logic [7:0]  RST_OV_FAULT_POLICY      = 8'h80;

    // Policy sequencer states, Gray coded along run, delay, down, retry, latch, hold.
    typedef enum logic [2:0] {
        OOFR_RUN   = 3'h0,
        OOFR_DELAY = 3'h1,
        OOFR_DOWN  = 3'h3,
        OOFR_RETRY = 3'h2,
        OOFR_LATCH = 3'h6,
        OOFR_HOLD  = 3'h7
    } oofr_state_t;

endpackage

`default_nettype wire

/* rtl/oofr_timer_if.sv */
// Interface between the policy sequencer and its delay timer.
// Assumes both ends run on the same clock.
`default_nettype none

interface oofr_timer_if;
    logic        start;
    logic [2:0]  code;
    logic [15:0] unitCycles;
    logic        expired;

    modport ctrl  (output start, output code, output unitCycles, input expired);
    modport timer (input start, input code, input unitCycles, output expired);
endinterface

`default_nettype wire

/* rtl/oofr_delay_timer.sv */
// Delay timer: counts two to the power of the delay code time units.
// Assumes unitCycles is the length of one time unit in clock cycles; zero counts as one.
`default_nettype none

module oofr_delay_timer
(
    input  wire logic     ref_clk,
    input  wire logic     rst_n,
    oofr_timer_if.timer   tmr
);

    typedef struct packed {
        logic        running;
        logic [15:0] cycles;
        logic [7:0]  units;
    } oofr_timer_state_t;

    oofr_timer_state_t st_reg;
    oofr_timer_state_t st_next;
    logic [15:0]       unitLen;
    logic [7:0]        unitTotal;
    logic              unitDone;
    logic              lastUnit;

    // A start while running restarts the count, so each attempt measures from its own start.
    always_comb
    begin
        st_next   = st_reg;
        unitLen   = (tmr.unitCycles == 16'h0000) ? 16'h0001 : tmr.unitCycles;
        unitTotal = 8'h01 << tmr.code; // R12
        unitDone  = st_reg.cycles + 16'h0001 >= unitLen; // R13
        lastUnit  = st_reg.units + 8'h01 == unitTotal;
        if (tmr.start)
        begin
            st_next.running = 1'b1;
            st_next.cycles  = 16'h0000;
            st_next.units   = 8'h00;
        end
        else if (st_reg.running)
        begin
            if (unitDone)
            begin
                st_next.cycles = 16'h0000;
                if (lastUnit)
                    st_next.running = 1'b0;
                else
                    st_next.units = st_reg.units + 8'h01;
            end
            else
            begin
                st_next.cycles = st_reg.cycles + 16'h0001;
            end
        end
    end

    // State register.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    // Expiry is decoded from the count so that the sequencer sees it on the last counted edge.
    assign tmr.expired = st_reg.running && unitDone && lastUnit; // R8

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_timer_expiry_from_run;
        tmr.expired && !tmr.start |=> !st_reg.running;
    endproperty
    a_timer_expiry_from_run: assert property (p_timer_expiry_from_run) // R12
        else $error("Timer kept running after expiry.");

    property p_timer_single_unit;
        tmr.start && tmr.code == 3'h0 && tmr.unitCycles == 16'h0001 ##1 !tmr.start
            |-> tmr.expired;
    endproperty
    a_timer_single_unit: assert property (p_timer_single_unit) // R8
        else $error("One-unit delay did not expire after one cycle.");

endmodule // oofr_delay_timer

`default_nettype wire

/* rtl/oofr_top.sv */
// Output over-voltage fault response: settings, fault detection, retry sequencing, offset.
// Assumes a bus engine that decodes host commands into cmdCode with write and read strobes,
// measurements that arrive as valid-qualified samples, and a time unit supplied from outside.
`default_nettype none

// Functional notes
// R1: Response 00 ignores the fault entirely.
// R2: Response 01 waits delay, retries if persisting.
// R3: Response 10 disables at once, then retries.
// R4: Response 11 holds off until fault clears.
// R5: Retry code 000 means latch off.
// R6: Codes 001-101 retry that many times.
// R7: Retry code 111 retries without limit.
// R8: Attempt starts spaced by the programmed delay.
// R9: Threshold is 16-bit unsigned, exponent minus twelve.
// R10: Offset added to every output current reading.
// R11: Retry code 110 retries six times.
// R12: Delay is two to the code units.
// R13: Time unit length comes from elsewhere.
// R14: Voltage above threshold is a fault.
// R15: Latch ends on clear or off-on.
module oofr_top
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  cmdCode,
    input  wire logic [15:0] wrData,
    input  wire logic        wrStrobe,
    input  wire logic        rdStrobe,
    output logic      [15:0] rdData,
    output logic             cmdInvalid,
    input  wire logic [15:0] voutSample,
    input  wire logic        voutValid,
    input  wire logic [15:0] ioutSample,
    input  wire logic        ioutValid,
    output logic      [15:0] ioutAdjusted,
    output logic             ioutAdjustedValid,
    input  wire logic [15:0] delayUnitCycles,
    input  wire logic        outputCommandOn,
    input  wire logic        faultClear,
    output logic             outputEnable,
    output logic             overvoltagePresent,
    output logic             latchedOff,
    output logic      [2:0]  retryAttempt
);

    typedef struct packed {
        oofr_pkg::oofr_state_t state;
        logic [2:0]            attempts;
        logic                  faultSeen;
        logic                  ovPresent;
        logic                  outEn;
        logic [15:0]           offset;
        logic [15:0]           threshold;
        logic [7:0]            policy;
        logic [15:0]           rdData;
        logic                  cmdInvalid;
        logic [15:0]           ioutAdj;
        logic                  ioutAdjValid;
    } oofr_top_state_t;

    oofr_top_state_t st_reg;
    oofr_top_state_t st_next;
    oofr_timer_if    tmrIf ();
    logic [1:0]      resp;
    logic [2:0]      retries;
    logic            timerStart;

    // Linear add: align the offset mantissa to the reading's exponent, add, saturate.
    function automatic logic [15:0] linAdd(input logic [15:0] rd, input logic [15:0] off);
        logic signed [5:0]  diff;
        logic signed [16:0] shifted;
        logic signed [16:0] sum;
        logic [10:0]        man;
        diff = $signed({rd[15], rd[15:11]});
        diff = $signed({off[15], off[15:11]}) - diff;
        shifted = $signed({{6{off[10]}}, off[10:0]});
        if (diff >= 6'sh00)
            shifted = shifted <<< diff[4:0];
        else
            shifted = shifted >>> 6'(-diff);
        sum = $signed({{6{rd[10]}}, rd[10:0]}) + shifted;
        if (sum > 17'sh003FF)
            man = 11'h3FF;
        else if (sum < -17'sh00400)
            man = 11'h400;
        else
            man = sum[10:0];
        return {rd[15:11], man};
    endfunction

    assign resp    = st_reg.policy[oofr_pkg::RESP_MSB:oofr_pkg::RESP_LSB];
    assign retries = st_reg.policy[oofr_pkg::RETRY_MSB:oofr_pkg::RETRY_LSB];

    // Command port, fault detection, current offset and the policy sequencer.
    always_comb
    begin
        st_next = st_reg;
        timerStart = 1'b0;
        st_next.cmdInvalid   = 1'b0;
        st_next.ioutAdjValid = 1'b0;
        if (wrStrobe)
        begin
            case (cmdCode)
                oofr_pkg::CMD_CURRENT_SENSE_OFFSET: st_next.offset = wrData;
                oofr_pkg::CMD_OV_FAULT_THRESHOLD:   st_next.threshold = wrData; // R9
                oofr_pkg::CMD_OV_FAULT_POLICY:      st_next.policy = wrData[7:0];
                default:                            st_next.cmdInvalid = 1'b1;
            endcase
        end
        if (rdStrobe)
        begin
            case (cmdCode)
                oofr_pkg::CMD_CURRENT_SENSE_OFFSET: st_next.rdData = st_reg.offset;
                oofr_pkg::CMD_OV_FAULT_THRESHOLD:   st_next.rdData = st_reg.threshold;
                oofr_pkg::CMD_OV_FAULT_POLICY:      st_next.rdData = {8'h00, st_reg.policy};
                default:
                begin
                    st_next.rdData     = 16'h0000;
                    st_next.cmdInvalid = 1'b1;
                end
            endcase
        end
        // Unsigned compare is valid because both words carry the same fixed exponent.
        if (voutValid)
            st_next.ovPresent = voutSample > st_reg.threshold; // R14
        if (ioutValid)
        begin
            st_next.ioutAdj      = linAdd(ioutSample, st_reg.offset); // R10
            st_next.ioutAdjValid = 1'b1;
        end
        // Turning the output off abandons any response, which also releases a latch.
        if (!outputCommandOn)
        begin
            st_next.state    = oofr_pkg::OOFR_RUN; // R15
            st_next.attempts = 3'h0;
        end
        else
        begin
            case (st_reg.state)
                oofr_pkg::OOFR_RUN:
                begin
                    if (st_reg.ovPresent) // R14
                    begin
                        case (resp)
                            oofr_pkg::RESP_DELAY_RETRY: // R2
                            begin
                                st_next.state = oofr_pkg::OOFR_DELAY;
                                timerStart = 1'b1;
                            end
                            oofr_pkg::RESP_DISABLE_RETRY: // R3
                            begin
                                st_next.state = oofr_pkg::OOFR_DOWN;
                                timerStart = 1'b1;
                            end
                            oofr_pkg::RESP_RESUME_OK: st_next.state = oofr_pkg::OOFR_HOLD; // R4
                            default:                  st_next.state = oofr_pkg::OOFR_RUN; // R1
                        endcase
                    end
                end
                oofr_pkg::OOFR_DELAY:
                begin
                    if (tmrIf.expired)
                    begin
                        if (!st_reg.ovPresent)
                            st_next.state = oofr_pkg::OOFR_RUN; // R2
                        else if (retries == oofr_pkg::RETRY_NONE)
                            st_next.state = oofr_pkg::OOFR_LATCH; // R5
                        else
                        begin
                            st_next.state = oofr_pkg::OOFR_DOWN;
                            timerStart = 1'b1;
                        end
                    end
                end
                oofr_pkg::OOFR_DOWN:
                begin
                    if (tmrIf.expired)
                    begin
                        if (retries == oofr_pkg::RETRY_NONE)
                            st_next.state = oofr_pkg::OOFR_LATCH; // R5
                        else
                        begin
                            st_next.state     = oofr_pkg::OOFR_RETRY;
                            st_next.attempts  = 3'h1;
                            st_next.faultSeen = 1'b0;
                            timerStart = 1'b1; // R8
                        end
                    end
                end
                oofr_pkg::OOFR_RETRY:
                begin
                    // A fault during an attempt drops the output but keeps the attempt spacing.
                    if (st_reg.ovPresent)
                        st_next.faultSeen = 1'b1;
                    if (tmrIf.expired)
                    begin
                        if (!st_reg.faultSeen && !st_reg.ovPresent)
                        begin
                            st_next.state    = oofr_pkg::OOFR_RUN;
                            st_next.attempts = 3'h0;
                        end
                        else if (retries == oofr_pkg::RETRY_FOREVER) // R7
                        begin
                            st_next.faultSeen = 1'b0;
                            timerStart = 1'b1;
                        end
                        else if (st_reg.attempts < retries) // R6 R11
                        begin
                            st_next.attempts  = st_reg.attempts + 3'h1;
                            st_next.faultSeen = 1'b0;
                            timerStart = 1'b1; // R8
                        end
                        else
                            st_next.state = oofr_pkg::OOFR_LATCH; // R6 R11
                    end
                end
                oofr_pkg::OOFR_LATCH:
                begin
                    if (faultClear)
                    begin
                        st_next.state    = oofr_pkg::OOFR_RUN; // R15
                        st_next.attempts = 3'h0;
                    end
                end
                oofr_pkg::OOFR_HOLD:
                begin
                    if (!st_reg.ovPresent)
                        st_next.state = oofr_pkg::OOFR_RUN; // R4
                end
                default: st_next.state = oofr_pkg::OOFR_RUN;
            endcase
        end
        // The output follows the next state so a disabling decision acts on the next edge.
        case (st_next.state)
            oofr_pkg::OOFR_RUN:   st_next.outEn = outputCommandOn;
            oofr_pkg::OOFR_DELAY: st_next.outEn = 1'b1; // R2
            oofr_pkg::OOFR_RETRY: st_next.outEn = !st_next.faultSeen;
            default:              st_next.outEn = 1'b0; // R3 R4 R5
        endcase
    end

    // State register; settings take their reset values here.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg           <= '0;
            st_reg.state     <= oofr_pkg::OOFR_RUN;
            st_reg.offset    <= oofr_pkg::RST_CURRENT_SENSE_OFFSET;
            st_reg.threshold <= oofr_pkg::RST_OV_FAULT_THRESHOLD;
            st_reg.policy    <= oofr_pkg::RST_OV_FAULT_POLICY;
        end
        else
            st_reg <= st_next;
    end

    assign tmrIf.start      = timerStart;
    assign tmrIf.code       = st_reg.policy[oofr_pkg::DELAY_MSB:oofr_pkg::DELAY_LSB];
    assign tmrIf.unitCycles = delayUnitCycles; // R13

    oofr_delay_timer u_timer
    (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .tmr     (tmrIf.timer)
    );

    assign rdData             = st_reg.rdData;
    assign cmdInvalid         = st_reg.cmdInvalid;
    assign ioutAdjusted       = st_reg.ioutAdj;
    assign ioutAdjustedValid  = st_reg.ioutAdjValid;
    assign outputEnable       = st_reg.outEn;
    assign overvoltagePresent = st_reg.ovPresent;
    assign latchedOff         = st_reg.state == oofr_pkg::OOFR_LATCH;
    assign retryAttempt       = st_reg.attempts;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_ignore;
        st_reg.state == oofr_pkg::OOFR_RUN && resp == oofr_pkg::RESP_IGNORE && outputCommandOn
            && !wrStrobe |=> st_reg.state == oofr_pkg::OOFR_RUN && outputEnable;
    endproperty
    a_ignore: assert property (p_ignore) // R1
        else $error("Ignored fault disturbed the output.");

    property p_delay_on;
        st_reg.state == oofr_pkg::OOFR_DELAY |-> outputEnable;
    endproperty
    a_delay_on: assert property (p_delay_on) // R2
        else $error("Output dropped during the grace delay.");

    property p_disable_now;
        st_reg.state == oofr_pkg::OOFR_RUN && st_reg.ovPresent && outputCommandOn
            && resp == oofr_pkg::RESP_DISABLE_RETRY |=> !outputEnable;
    endproperty
    a_disable_now: assert property (p_disable_now) // R3
        else $error("Output not disabled on the edge after the fault.");

    property p_hold;
        st_reg.state == oofr_pkg::OOFR_HOLD |-> (!outputEnable
            and (outputCommandOn && !st_reg.ovPresent |=> st_reg.state == oofr_pkg::OOFR_RUN));
    endproperty
    a_hold: assert property (p_hold) // R4
        else $error("Hold state did not track the fault.");

    property p_no_retry;
        st_reg.state == oofr_pkg::OOFR_DOWN && tmrIf.expired && outputCommandOn
            && retries == oofr_pkg::RETRY_NONE |=> latchedOff;
    endproperty
    a_no_retry: assert property (p_no_retry) // R5
        else $error("Retry code zero did not latch off.");

    property p_retry_limit;
        st_reg.state == oofr_pkg::OOFR_RETRY && tmrIf.expired && outputCommandOn
            && st_reg.faultSeen && retries != oofr_pkg::RETRY_FOREVER
            |=> (latchedOff == ($past(st_reg.attempts) >= $past(retries)));
    endproperty
    a_retry_limit: assert property (p_retry_limit) // R6
        else $error("Retry count limit not honoured.");

    property p_forever;
        retries == oofr_pkg::RETRY_FOREVER && !wrStrobe
            && st_reg.state == oofr_pkg::OOFR_RETRY |=> !latchedOff;
    endproperty
    a_forever: assert property (p_forever) // R7
        else $error("Continuous retry latched off.");

    property p_latch_stays;
        latchedOff && outputCommandOn && !faultClear |=> latchedOff;
    endproperty
    a_latch_stays: assert property (p_latch_stays) // R15
        else $error("Latched state left without clear or off command.");

    property p_threshold_write;
        wrStrobe && cmdCode == oofr_pkg::CMD_OV_FAULT_THRESHOLD
            |=> st_reg.threshold == $past(wrData) ##1 overvoltagePresent == $past(overvoltagePresent)
                || $past(voutValid);
    endproperty
    a_threshold_write: assert property (p_threshold_write) // R9
        else $error("Threshold write did not store the data.");

    c_retry_attempt: cover property (st_reg.state == oofr_pkg::OOFR_RETRY && tmrIf.expired);
    c_latched:       cover property ($rose(latchedOff));
    c_hold_resume:   cover property (st_reg.state == oofr_pkg::OOFR_HOLD
                                     ##1 st_reg.state == oofr_pkg::OOFR_RUN);
    c_delay_recover: cover property (st_reg.state == oofr_pkg::OOFR_DELAY
                                     ##1 st_reg.state == oofr_pkg::OOFR_RUN);

endmodule // oofr_top

`default_nettype wire

/* verif/oofr_host.sv */
// Host model: issues setting writes and reads on the command port.
// Assumes the block answers one cycle after the strobe edge.
`default_nettype none

module oofr_host
(
    input  wire logic        ref_clk,
    output logic      [7:0]  cmdCode,
    output logic      [15:0] wrData,
    output logic             wrStrobe,
    output logic             rdStrobe
);
    timeunit 1ns;
    timeprecision 1ns;

    // Lines idle low; released data is inverted so stale values never look valid.
    initial
    begin
        cmdCode = 8'h00;
        wrData = 16'h0000;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
    end

    task automatic access(input logic [7:0] c, input logic [15:0] d, input logic w);
        @(negedge ref_clk);
        cmdCode <= c;
        wrData <= d;
        wrStrobe <= w;
        rdStrobe <= !w;
        @(negedge ref_clk);
        wrStrobe <= 1'b0;
        rdStrobe <= 1'b0;
        wrData <= ~d;
    endtask
endmodule // oofr_host

`default_nettype wire

/* verif/output_overvoltage_fault_response_bench.sv */
// Bench for the fault response block: settings, offset and retry policy.
// Assumes the host model drives commands and this bench drives measurements.
`default_nettype none

module output_overvoltage_fault_response_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  cmdCode;
    logic [15:0] wrData;
    logic        wrStrobe;
    logic        rdStrobe;
    logic [15:0] rdData;
    logic        cmdInvalid;
    logic [15:0] voutSample = 16'h0000;
    logic        voutValid = 1'b1;
    logic [15:0] ioutSample = 16'h0000;
    logic        ioutValid = 1'b0;
    logic [15:0] ioutAdjusted;
    logic        ioutAdjustedValid;
    logic [15:0] delayUnitCycles = 16'h0001;
    logic        outputCommandOn = 1'b1;
    logic        faultClear = 1'b0;
    logic        outputEnable;
    logic        overvoltagePresent;
    logic        latchedOff;
    logic [2:0]  retryAttempt;
    int          mismatches = 0;
    int          compares = 0;

    // Clock at 125 MHz.
    always #4 ref_clk = ~ref_clk;

    oofr_host host (.ref_clk(ref_clk), .cmdCode(cmdCode), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe));

    oofr_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .cmdCode(cmdCode), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .cmdInvalid(cmdInvalid),
        .voutSample(voutSample), .voutValid(voutValid), .ioutSample(ioutSample),
        .ioutValid(ioutValid), .ioutAdjusted(ioutAdjusted),
        .ioutAdjustedValid(ioutAdjustedValid), .delayUnitCycles(delayUnitCycles),
        .outputCommandOn(outputCommandOn), .faultClear(faultClear),
        .outputEnable(outputEnable), .overvoltagePresent(overvoltagePresent),
        .latchedOff(latchedOff), .retryAttempt(retryAttempt));

    task automatic end_sim();
        if (mismatches == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        host.access(c, 16'h0000, 1'b0);
        chk("rdData", rdData, e);
    endtask

    task automatic volt(input logic [15:0] v, input int n);
        voutSample = v;
        cyc(n);
    endtask

    task automatic clr();
        faultClear = 1'b1;
        cyc(1);
        faultClear = 1'b0;
        cyc(2);
    endtask

    // Reset values, write then read back, and an unmapped command.
    task automatic t_regs();
        rd(8'h39, oofr_pkg::RST_CURRENT_SENSE_OFFSET);
        rd(8'h40, oofr_pkg::RST_OV_FAULT_THRESHOLD);
        rd(8'h41, {8'h00, oofr_pkg::RST_OV_FAULT_POLICY});
        rd(8'h50, 16'h0000);
        chk("cmdInvalid", 16'(cmdInvalid), 16'h0001);
        host.access(8'h40, 16'h1000, 1'b1);
        rd(8'h40, 16'h1000);
    endtask

    // One current reading against an offset; exponents may differ.
    task automatic t_iout(input logic [15:0] off, input logic [15:0] s, input logic [15:0] e);
        host.access(8'h39, off, 1'b1);
        ioutSample = s;
        ioutValid = 1'b1;
        cyc(1);
        ioutValid = 1'b0;
        ioutSample = ~s;
        chk("ioutAdjustedValid", 16'(ioutAdjustedValid), 16'h0001);
        chk("ioutAdjusted", ioutAdjusted, e);
    endtask

    // Ignore policy; a sample equal to the limit is not a fault.
    task automatic t_ignore();
        host.access(8'h41, 16'h0000, 1'b1);
        volt(16'h1000, 3);
        chk("overvoltagePresent", 16'(overvoltagePresent), 16'h0000);
        volt(16'hF000, 6);
        chk("overvoltagePresent", 16'(overvoltagePresent), 16'h0001);
        chk("outputEnable", 16'(outputEnable), 16'h0001);
        volt(16'h0800, 3);
        host.access(8'h41, 16'h00C0, 1'b1);
        volt(16'hF000, 3);
        chk("outputEnable", 16'(outputEnable), 16'h0000);
        volt(16'h0800, 3);
        chk("outputEnable", 16'(outputEnable), 16'h0001);
    endtask

    // Disable without retry latches; exit by clear or by an off-on command.
    task automatic t_latch(input logic byClear);
        host.access(8'h41, 16'h0080, 1'b1);
        volt(16'hF000, 2);
        chk("outputEnable", 16'(outputEnable), 16'h0000);
        volt(16'h0800, 10);
        chk("latchedOff", 16'(latchedOff), 16'h0001);
        if (byClear)
            clr();
        else
        begin
            outputCommandOn = 1'b0;
            cyc(2);
            outputCommandOn = 1'b1;
            cyc(2);
        end
        chk("latchedOff", 16'(latchedOff), 16'h0000);
        chk("outputEnable", 16'(outputEnable), 16'h0001);
    endtask

    // Persistent fault against each retry code from 001 to 111.
    task automatic t_retry(input logic [2:0] r);
        int top = 0;
        host.access(8'h41, {8'h00, 2'b10, r, 3'b000}, 1'b1);
        voutSample = 16'hF000;
        repeat (120)
        begin
            cyc(1);
            if (retryAttempt > top) top = retryAttempt;
        end
        chk("latchedOff", 16'(latchedOff), 16'(r != 3'h7));
        if (r != 3'h7) chk("retryAttempt", 16'(top), 16'(r));
        volt(16'h0800, 40);
        clr();
        chk("outputEnable", 16'(outputEnable), 16'h0001);
    endtask

    // Start-to-start spacing of attempts for one delay code, unit of three clocks.
    task automatic t_space(input logic [2:0] c, output int sp);
        int n = 0;
        delayUnitCycles = 16'h0003;
        host.access(8'h41, {8'h00, 2'b10, 3'h6, c}, 1'b1);
        voutSample = 16'hF000;
        while (retryAttempt !== 3'h1 && n < 300)
        begin
            cyc(1);
            n++;
        end
        sp = 0;
        while (retryAttempt === 3'h1 && sp < 300)
        begin
            cyc(1);
            sp++;
        end
        chk("spacing", 16'(sp), 16'(3 * (1 << c)));
        volt(16'h0800, 80);
        clr();
        delayUnitCycles = 16'h0002;
    endtask

    // Delayed response: short fault rides through, lasting fault latches.
    task automatic t_delay();
        delayUnitCycles = 16'h0004;
        host.access(8'h41, 16'h0041, 1'b1);
        volt(16'hF000, 3);
        chk("outputEnable", 16'(outputEnable), 16'h0001);
        volt(16'h0800, 14);
        chk("latchedOff", 16'(latchedOff), 16'h0000);
        volt(16'hF000, 14);
        chk("latchedOff", 16'(latchedOff), 16'h0001);
        chk("outputEnable", 16'(outputEnable), 16'h0000);
        volt(16'h0800, 2);
        clr();
        delayUnitCycles = 16'h0002;
    endtask

    // Main sequence after four cycles of reset.
    initial
    begin : main_seq
        int s2;
        int s3;
        cyc(4);
        rst_n = 1'b1;
        cyc(1);
        t_regs();
        t_iout(16'h0005, 16'h0010, 16'h0015);
        t_iout(16'h07FF, 16'h0010, 16'h000F);
        t_iout(16'h0003, 16'hF804, 16'hF80A);
        t_ignore();
        t_latch(1'b1);
        t_latch(1'b0);
        t_delay();
        for (int r = 1; r < 8; r++) t_retry(3'(r));
        t_space(3'h2, s2);
        t_space(3'h3, s3);
        chk("unitScale", 16'(s3 - s2), 16'h000C);
        end_sim();
    end

    // The sequence needs about 1500 cycles; a hang is cut at twenty times that.
    initial
    begin
        #240000;
        mismatches++;
        end_sim();
    end
endmodule // output_overvoltage_fault_response_bench

`default_nettype wire
